// ==== logic/ssmt_alu.v ====
// execution slice for subtract, nibble swap and complement test, with its own
// 256-byte register file; software loads operands and starts an instruction over apb
// assumes a single 125 MHz clock and an apb master that waits on pready
`timescale 1ns/1ps
`default_nettype none
`include "ssmt_alu_map.vh"

module ssmt_alu #(
    parameter RF_DEPTH = 256
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire busy,
    output reg done_q
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] opc_q;
reg [7:0] dop_q;
reg [7:0] sop_q;
reg [5:0] flg_q;
reg [7:0] rp_q;
reg [7:0] res_q;
reg [7:0] rf_idx_q;
reg [3:0] cnt_q;
reg busy_q;
reg bad_q;
reg [31:0] rdata_q;
reg [7:0] rf [0:RF_DEPTH-1];

wire wr = psel & penable & pwrite;
wire rd = psel & ~penable & ~pwrite;

////////////////////////////////////////////////////////////////////////////////
// decode
wire [3:0] hi = opc_q[7:4];
wire [3:0] lo = opc_q[3:0];
wire is_sub = (hi == `SSMT_HI_SUB) && (lo >= `SSMT_LO_RR) && (lo <= `SSMT_LO_IR_IM);
wire is_tcm = (hi == `SSMT_HI_TCM) && (lo >= `SSMT_LO_RR) && (lo <= `SSMT_LO_IR_IM);
wire is_swp = (opc_q == `SSMT_OP_SWAP_R) || (opc_q == `SSMT_OP_SWAP_IR);
wire two_op = is_sub | is_tcm;

// short forms carry 4-bit working register numbers
function [7:0] wreg;
    input [7:0] rp;
    input [3:0] n;
    begin
        wreg = {rp[7:4], n};
    end
endfunction

// full register operand, with the 1110b escape into the working group
function [7:0] raddr;
    input [7:0] rp;
    input [7:0] b;
    begin
        if (b[7:4] == `SSMT_WREG_ESC) begin
            raddr = wreg(rp, b[3:0]);
        end else begin
            raddr = b;
        end
    end
endfunction

reg [7:0] d_addr;
reg [7:0] s_val;
reg s_ind;
reg [7:0] s_addr;
always @* begin
    d_addr = raddr(rp_q, dop_q);
    s_addr = raddr(rp_q, sop_q);
    s_ind = 1'b0;
    s_val = 8'h00;
    if (is_swp) begin
        if (opc_q == `SSMT_OP_SWAP_IR) begin
            d_addr = rf[raddr(rp_q, dop_q)];
        end
    end else begin
        case (lo)
            `SSMT_LO_RR: begin
                d_addr = wreg(rp_q, dop_q[3:0]);
                s_val = rf[wreg(rp_q, sop_q[3:0])];
            end
            `SSMT_LO_RIR: begin
                d_addr = wreg(rp_q, dop_q[3:0]);
                s_val = rf[rf[wreg(rp_q, sop_q[3:0])]];
            end
            `SSMT_LO_R_R: s_val = rf[s_addr];
            `SSMT_LO_R_IR: s_val = rf[rf[s_addr]];
            `SSMT_LO_R_IM: s_val = sop_q;
            `SSMT_LO_IR_IM: begin
                d_addr = rf[raddr(rp_q, dop_q)];
                s_val = sop_q;
            end
            default: s_ind = 1'b1;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// arithmetic
wire [7:0] d_val = rf[d_addr];
wire [7:0] s_cpl = ~s_val;
wire [8:0] sum = {1'b0, d_val} + {1'b0, s_cpl} + 9'h001;
wire [4:0] hsum = {1'b0, d_val[3:0]} + {1'b0, s_cpl[3:0]} + 5'h01;
wire [7:0] tcm_r = ~d_val & s_val;
wire [7:0] swp_r = {d_val[3:0], d_val[7:4]};

reg [7:0] r;
reg [5:0] f_d;
always @* begin
    r = 8'h00;
    f_d = flg_q;
    if (is_sub) begin
        r = sum[7:0];
        f_d[`SSMT_F_C] = ~sum[8];
        f_d[`SSMT_F_Z] = (sum[7:0] == 8'h00);
        f_d[`SSMT_F_V] = (d_val[7] ^ s_val[7]) & (sum[7] == s_val[7]);
        f_d[`SSMT_F_S] = sum[7];
        f_d[`SSMT_F_H] = ~hsum[4];
        f_d[`SSMT_F_D] = 1'b1;
    end else if (is_swp) begin
        // overflow is undefined here; it is simply left as it was
        r = swp_r;
        f_d[`SSMT_F_Z] = (swp_r == 8'h00);
        f_d[`SSMT_F_S] = swp_r[7];
    end else if (is_tcm) begin
        r = tcm_r;
        f_d[`SSMT_F_Z] = (tcm_r == 8'h00);
        f_d[`SSMT_F_S] = tcm_r[7];
        f_d[`SSMT_F_V] = 1'b0;
    end
end

// short forms and swap take 6 cycles, the rest 10
wire [3:0] cyc = (is_swp || lo == `SSMT_LO_RR || lo == `SSMT_LO_RIR) ?
    `SSMT_CYC_SHORT : `SSMT_CYC_LONG;
wire legal = two_op | is_swp;

////////////////////////////////////////////////////////////////////////////////
// sequencing; operands and file are frozen while busy so the result is stable
// at the last cycle, where write-back and flag update happen together
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        opc_q <= 8'h00;
        dop_q <= 8'h00;
        sop_q <= 8'h00;
        flg_q <= 6'h00;
        rp_q <= 8'h00;
        res_q <= 8'h00;
        rf_idx_q <= 8'h00;
        cnt_q <= 4'h0;
        busy_q <= 1'b0;
        bad_q <= 1'b0;
        done_q <= 1'b0;
    end else begin
        done_q <= 1'b0;
        if (busy_q) begin
            if (cnt_q == 4'd1) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                flg_q <= f_d;
                res_q <= r;
            end
            cnt_q <= cnt_q - 4'd1;
        end else if (wr) begin
            case (paddr)
                `SSMT_A_CMD: begin
                    opc_q <= pwdata[7:0];
                    bad_q <= 1'b0;
                end
                `SSMT_A_OPS: begin
                    dop_q <= pwdata[7:0];
                    sop_q <= pwdata[15:8];
                end
                `SSMT_A_FLG: flg_q <= pwdata[5:0];
                `SSMT_A_RP: rp_q <= pwdata[7:0];
                `SSMT_A_RF: rf_idx_q <= pwdata[15:8];
                default: ;
            endcase
        end else if (opc_q != 8'h00) begin
            // a written opcode starts once the bus write has completed
            opc_q <= legal ? opc_q : 8'h00;
            bad_q <= ~legal;
            busy_q <= legal;
            cnt_q <= cyc;
        end
        if (busy_q && cnt_q == 4'd1) begin
            opc_q <= 8'h00;
        end
    end
end

// register file: written by bus and by the write-back; no reset, like core ram
always @(posedge pclk) begin
    if (busy_q && cnt_q == 4'd1 && (is_sub || is_swp)) begin
        rf[d_addr] <= r;
    end else if (!busy_q && wr && paddr == `SSMT_A_RF) begin
        rf[pwdata[15:8]] <= pwdata[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb read path: no wait state, data registered in the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rdata_q <= 32'h0000_0000;
    end else if (rd) begin
        case (paddr)
            `SSMT_A_CMD: rdata_q <= {24'h000000, opc_q};
            `SSMT_A_OPS: rdata_q <= {16'h0000, sop_q, dop_q};
            `SSMT_A_FLG: rdata_q <= {26'h0000000, flg_q};
            `SSMT_A_STA: rdata_q <= {30'h00000000, bad_q, busy_q};
            `SSMT_A_RES: rdata_q <= {24'h000000, res_q};
            `SSMT_A_RP: rdata_q <= {24'h000000, rp_q};
            `SSMT_A_RF: rdata_q <= {16'h0000, rf_idx_q, rf[rf_idx_q]};
            default: rdata_q <= 32'h0000_0000;
        endcase
    end
end

wire mapped = (paddr == `SSMT_A_CMD) || (paddr == `SSMT_A_OPS) || (paddr == `SSMT_A_FLG) ||
    (paddr == `SSMT_A_STA) || (paddr == `SSMT_A_RES) || (paddr == `SSMT_A_RP) ||
    (paddr == `SSMT_A_RF);

// writes wait out a running instruction; reads never stall
assign pready = ~(pwrite & busy_q);
assign pslverr = psel & penable & ~mapped;
assign prdata = rdata_q;
assign busy = busy_q;

endmodule // ssmt_alu
`default_nettype wire

// ==== logic/ssmt_alu_map.vh ====
// constants for the subtract / nibble-swap / complement-test execution slice
// assumes inclusion by bare name from the slice module
`ifndef SSMT_ALU_MAP_VH
`define SSMT_ALU_MAP_VH
// opcode high nibbles, full swap opcodes and low-nibble forms
`define SSMT_HI_SUB 4'h2
`define SSMT_HI_TCM 4'h6
`define SSMT_OP_SWAP_R 8'hf0
`define SSMT_OP_SWAP_IR 8'hf1
`define SSMT_LO_RR 4'h2
`define SSMT_LO_RIR 4'h3
`define SSMT_LO_R_R 4'h4
`define SSMT_LO_R_IR 4'h5
`define SSMT_LO_R_IM 4'h6
`define SSMT_LO_IR_IM 4'h7
// working-register escape in an operand byte
`define SSMT_WREG_ESC 4'he
// cycle counts
`define SSMT_CYC_SHORT 4'd6
`define SSMT_CYC_LONG 4'd10
// flag bit positions in the flag register
`define SSMT_F_C 5
`define SSMT_F_Z 4
`define SSMT_F_S 3
`define SSMT_F_V 2
`define SSMT_F_D 1
`define SSMT_F_H 0
// register offsets over apb
`define SSMT_A_CMD 12'h000
`define SSMT_A_OPS 12'h004
`define SSMT_A_FLG 12'h008
`define SSMT_A_STA 12'h00c
`define SSMT_A_RES 12'h010
`define SSMT_A_RP 12'h014
`define SSMT_A_RF 12'h018
`endif

// ==== test/ssmt_alu_sva.sv ====
// checker bound onto the slice ports
// assumes the map header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "ssmt_alu_map.vh"
module ssmt_alu_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy,
    input wire logic done_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire cmd = psel && penable && pready && pwrite && paddr == `SSMT_A_CMD;
    wire two = pwdata[7:4] == `SSMT_HI_SUB || pwdata[7:4] == `SSMT_HI_TCM;
    a_short_len: assert property (cmd && two && pwdata[3:1] == 3'h1 |=> ##1 busy[*6] ##1 done_q)
        else $error("short form length wrong");
    a_long_len: assert property (cmd && two && pwdata[3:2] == 2'h1 |=> ##1
        busy[*8] ##1 busy[*2] ##1 done_q) else $error("long form length wrong");
    a_swap_len: assert property (cmd && pwdata[7:1] == 7'h78 |=> ##1 busy[*6] ##1 done_q)
        else $error("swap length wrong");
    a_done_pulse: assert property (done_q |=> !done_q) else $error("done longer than one cycle");
    a_done_ends: assert property ($fell(busy) |-> done_q) else $error("busy fell without done");
    a_wr_stall: assert property (psel && penable && pwrite && busy |-> !pready)
        else $error("write accepted while busy");
    a_rd_nowait: assert property (psel && penable && !pwrite |-> pready) else $error("read waited");
    a_bad_addr: assert property (psel && penable && paddr > `SSMT_A_RF |-> pslverr)
        else $error("unmapped access not flagged");
endmodule // ssmt_alu_sva
`default_nettype wire

// ==== test/ssmt_alu_tb.sv ====
// self-checking bench for the subtract, swap and complement-test slice
// assumes the host model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "ssmt_alu_map.vh"
module ssmt_alu_tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    wire logic psel, penable, pwrite, pready, pslverr, busy, done_q;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int bad_count = 0, samples_checked = 0;
    always #4 pclk = ~pclk;
    ssmt_apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ssmt_alu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busy(busy), .done_q(done_q));
    task tally_and_finish;
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); host_u.xfer(1'h1, a, d); endtask
    task rf(input logic [7:0] i, input logic [7:0] v); wr(`SSMT_A_RF, {16'h0, i, v}); endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        host_u.xfer(1'h0, a, 32'h0);
        chk(nm, host_u.rdat, exp);
    endtask
    // preload pairs go out highest first, so the last pair sets the file read index
    task go(input logic [7:0] op, input logic [7:0] f, input logic [15:0] ops,
            input logic [47:0] pre, input logic [31:0] exp);
        for (int k = 2; k >= 0; k--)
            if (pre[k*16+8 +: 8] != 8'h0) rf(pre[k*16+8 +: 8], pre[k*16 +: 8]);
        wr(`SSMT_A_FLG, {24'h0, f});
        wr(`SSMT_A_OPS, {16'h0, ops});
        wr(`SSMT_A_CMD, {24'h0, op});
        // stalls until the instruction retires, which saves a separate wait on done
        wr(`SSMT_A_RP, 32'h10);
        rdc("result", `SSMT_A_RES, {24'h0, exp[31:24]});
        rdc("flags", `SSMT_A_FLG, {24'h0, exp[23:16]});
        rdc("file", `SSMT_A_RF, {16'h0, exp[15:0]});
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        wr(`SSMT_A_RP, 32'h10);
        go(8'h22, 8'h3f, 16'h0b03, 48'h00001b201316, 32'hf62a13f6);
        go(8'h23, 8'h3f, 16'h0a05, 48'h1a2020111516, 32'h05021505);
        go(8'h24, 8'h3f, 16'he234, 48'h0000121b342e, 32'h13023413);
        go(8'h25, 8'h3f, 16'he34b, 48'h134040014b82, 32'h810a4b81);
        go(8'h26, 8'h3f, 16'h016c, 48'h000000006c80, 32'h7f076c7f);
        go(8'h27, 8'h3f, 16'h05d4, 48'h0000d45f5f05, 32'h00125f00);
        go(8'hf0, 8'h27, 16'h00bc, 48'h00000000bcb3, 32'h3b27bc3b);
        go(8'hf1, 8'h00, 16'h00e5, 48'h000015c0c00e, 32'he008c0e0);
        go(8'h62, 8'h27, 16'h0703, 48'h000017011345, 32'h00331345);
        go(8'h63, 8'h27, 16'h050e, 48'h15cbcb881ef3, 32'h08231ef3);
        go(8'h64, 8'h27, 16'he0d4, 48'h00001080d404, 32'h802bd404);
        go(8'h65, 8'h27, 16'h07df, 48'h071f1fbddfff, 32'h0033dfff);
        go(8'h66, 8'h27, 16'h02ed, 48'h000000001df1, 32'h02231df1);
        go(8'h67, 8'h27, 16'h105d, 48'h00005da0a00f, 32'h1023a00f);
        // an opcode outside the decoded set must not start and must be flagged
        wr(`SSMT_A_CMD, 32'h21);
        rdc("status", `SSMT_A_STA, 32'h2);
        rdc("cmd", `SSMT_A_CMD, 32'h0);
        host_u.xfer(1'h0, 12'h01c, 32'h0);
        chk("slverr", {31'h0, host_u.err}, 32'h1);
        chk("unmapped", host_u.rdat, 32'h0);
        tally_and_finish;
    end
endmodule // ssmt_alu_tb
bind ssmt_alu ssmt_alu_sva sva_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .done_q(done_q));
`default_nettype wire

// ==== test/ssmt_apb_host.sv ====
// apb master standing in for the core sequencer
// assumes each transfer is started right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module ssmt_apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rdat;
    logic err;
    initial {psel, penable, pwrite, paddr, pwdata} = 46'h0;
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        // the iff looks at pready as it stands at the edge, before that edge's updates land
        @(posedge pclk iff (pready === 1'h1));
        rdat = prdata;
        err = pslverr;
        // released lines show the inverse so a stale value is never taken as valid
        {psel, penable, paddr, pwdata} <= {2'h0, ~a, ~d};
    endtask
endmodule // ssmt_apb_host
`default_nettype wire
